// [logic/monitor_consts.svh]
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// register pointers
`define CFG_PTR 8'h00
`define DROP_PTR 8'h01

// reset values and fixed fields
`define CFG_RESET 16'h4127
`define DROP_RESET 16'h0000
`define RSV_PATTERN 3'h4
`define SRST_BIT 15
`define CFG_KEEP_HI 11

// serial address, value is arbitrary
`define DEV_ADDR 7'h40

// conversion times in ns and clock period
`define CLK_NS 40
`define CT0_NS 140000
`define CT1_NS 204000
`define CT2_NS 332000
`define CT3_NS 588000
`define CT4_NS 1100000
`define CT5_NS 2116000
`define CT6_NS 4156000
`define CT7_NS 8244000
`define CT0_CYC 18'(`CT0_NS / `CLK_NS)
`define CT1_CYC 18'(`CT1_NS / `CLK_NS)
`define CT2_CYC 18'(`CT2_NS / `CLK_NS)
`define CT3_CYC 18'(`CT3_NS / `CLK_NS)
`define CT4_CYC 18'(`CT4_NS / `CLK_NS)
`define CT5_CYC 18'(`CT5_NS / `CLK_NS)
`define CT6_CYC 18'(`CT6_NS / `CLK_NS)
`define CT7_CYC 18'(`CT7_NS / `CLK_NS)

`endif

// [logic/monitor_pkg.sv]
package monitor_pkg;

  typedef struct packed {
    logic srst;
    logic [2:0] fixed_bits;
    logic [2:0] sample_count_select;
    logic [2:0] rail_sample_period;
    logic [2:0] drop_sample_period;
    logic [2:0] op_select;
  } setup_t;

  typedef struct packed {
    logic valid;
    logic [7:0] ptr;
    logic [15:0] data;
  } reg_write_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_DROP = 3'h2,
    SEQ_RAIL = 3'h4
  } seq_state_t;

  typedef enum logic [5:0] {
    L_IDLE = 6'h01,
    L_ADDR = 6'h02,
    L_ACK = 6'h04,
    L_RX = 6'h08,
    L_TX = 6'h10,
    L_TXACK = 6'h20
  } link_state_t;

endpackage : monitor_pkg

// [logic/serial_reg_port.sv]
`include "monitor_consts.svh"

module serial_reg_port import monitor_pkg::*; #(
  parameter logic [6:0] dev_addr = `DEV_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // register side
  input wire logic [15:0] rd_word,
  output reg_write_t wr,
  output logic [7:0] ptr,
  output logic cfg_busy
);

  logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
  logic start_c, stop_c, rise_c, fall_c;
  link_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next, hi_reg, hi_next;
  logic [15:0] tx_reg, tx_next, word;
  logic [1:0] idx_reg, idx_next;
  logic rw_reg, rw_next, half_reg, half_next, oe_reg, oe_next, busy_reg, busy_next;
  reg_write_t wr_reg, wr_next;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_meta <= 1'h1;
      scl_sync <= 1'h1;
      scl_prev <= 1'h1;
      sda_meta <= 1'h1;
      sda_sync <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign start_c = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_c = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign rise_c = scl_sync & ~scl_prev;
  assign fall_c = ~scl_sync & scl_prev;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    hi_next = hi_reg;
    tx_next = tx_reg;
    idx_next = idx_reg;
    rw_next = rw_reg;
    half_next = half_reg;
    oe_next = oe_reg;
    busy_next = busy_reg;
    wr_next = wr_reg;
    wr_next.valid = 1'h0;
    word = half_reg ? rd_word : tx_reg;
    if (start_c) begin
      st_next = L_ADDR;
      cnt_next = 4'h0;
      idx_next = 2'h0;
      oe_next = 1'h0;
      busy_next = 1'h0;
    end else if (stop_c) begin
      st_next = L_IDLE;
      oe_next = 1'h0;
      busy_next = 1'h0;
    end else begin
      case (st_reg)
        L_IDLE: begin
          oe_next = 1'h0;
        end
        L_ADDR, L_RX: begin
          if (rise_c) begin
            shift_next = {shift_reg[6:0], sda_sync};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall_c && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            oe_next = 1'h1;
            st_next = L_ACK;
            if (st_reg == L_ADDR) begin
              rw_next = shift_reg[0];
              tx_next = rd_word;
              half_next = 1'h0;
              if (shift_reg[7:1] != dev_addr) begin
                oe_next = 1'h0;
                st_next = L_IDLE;
              end
            end else if (idx_reg == 2'h0) begin
              ptr_next = shift_reg;
              idx_next = 2'h1;
            end else if (idx_reg == 2'h1) begin
              hi_next = shift_reg;
              idx_next = 2'h2;
              busy_next = (ptr_reg == `CFG_PTR);
            end else begin
              wr_next = '{valid: 1'h1, ptr: ptr_reg, data: {hi_reg, shift_reg}};
              idx_next = 2'h1;
              busy_next = 1'h0;
            end
          end
        end
        L_ACK: begin
          if (fall_c) begin
            oe_next = 1'h0;
            st_next = L_RX;
            if (rw_reg) begin
              oe_next = ~tx_reg[15];
              tx_next = {tx_reg[14:0], 1'h0};
              st_next = L_TX;
            end
          end
        end
        L_TX: begin
          if (rise_c) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall_c && cnt_reg == 4'h8) begin
            oe_next = 1'h0;
            st_next = L_TXACK;
          end else if (fall_c) begin
            oe_next = ~tx_reg[15];
            tx_next = {tx_reg[14:0], 1'h0};
          end
        end
        L_TXACK: begin
          if (rise_c && sda_sync) begin
            st_next = L_IDLE;
          end else if (fall_c) begin
            // low byte follows high byte, then the word is fetched again
            half_next = ~half_reg;
            oe_next = ~word[15];
            tx_next = {word[14:0], 1'h0};
            cnt_next = 4'h0;
            st_next = L_TX;
          end
        end
        default: begin
          st_next = L_IDLE;
          oe_next = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= L_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      hi_reg <= 8'h00;
      tx_reg <= 16'h0000;
      idx_reg <= 2'h0;
      rw_reg <= 1'h0;
      half_reg <= 1'h0;
      oe_reg <= 1'h0;
      busy_reg <= 1'h0;
      wr_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      hi_reg <= hi_next;
      tx_reg <= tx_next;
      idx_reg <= idx_next;
      rw_reg <= rw_next;
      half_reg <= half_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      wr_reg <= wr_next;
    end
  end

  // open-drain: only ever pulls low
  assign sda_out = 1'h0;
  assign sda_oe = oe_reg;
  assign wr = wr_reg;
  assign ptr = ptr_reg;
  assign cfg_busy = busy_reg;

endmodule : serial_reg_port

// [logic/monitor_conversion_config.sv]
`include "monitor_consts.svh"

module monitor_conversion_config import monitor_pkg::*; #(
  parameter logic [17:0] ct_cycles [8] = '{`CT0_CYC, `CT1_CYC, `CT2_CYC, `CT3_CYC,
                                           `CT4_CYC, `CT5_CYC, `CT6_CYC, `CT7_CYC}
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // converter side
  input wire logic [15:0] drop_sample,
  output logic sample_taken,
  output logic conv_done
);

  setup_t cfg_reg, cfg_next;
  logic [15:0] drop_result_reg, drop_result_next, rd_word, avg_value;
  seq_state_t seq_reg, seq_next, first_state;
  logic [17:0] timer_reg, timer_next, phase_len;
  logic [10:0] pass_reg, pass_next, pass_last;
  logic signed [25:0] acc_reg, acc_next, acc_sum;
  logic kick_reg, kick_next, strobe_reg, strobe_next, done_reg, done_next;
  logic drop_en, rail_en, continuous, powerdown, phase_end, end_pass, wr_cfg, cfg_busy;
  logic [3:0] avg_shift;
  reg_write_t wr;
  logic [7:0] ptr;

  serial_reg_port port_u (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .rd_word(rd_word),
    .wr(wr),
    .ptr(ptr),
    .cfg_busy(cfg_busy)
  );

  // reads never disturb the sequencer
  assign rd_word = (ptr == `CFG_PTR) ? cfg_reg :
                   (ptr == `DROP_PTR) ? drop_result_reg : 16'h0000;
  assign wr_cfg = wr.valid && wr.ptr == `CFG_PTR;

  assign drop_en = cfg_reg.op_select[0];
  assign rail_en = cfg_reg.op_select[1];
  assign continuous = cfg_reg.op_select[2];
  assign powerdown = ~drop_en & ~rail_en;
  assign first_state = drop_en ? SEQ_DROP : SEQ_RAIL;

  always_comb begin
    case (cfg_reg.sample_count_select)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  end
  assign pass_last = 11'((12'h1 << avg_shift) - 12'h1);

  assign phase_len = (seq_reg == SEQ_DROP) ? ct_cycles[cfg_reg.drop_sample_period] :
                     ct_cycles[cfg_reg.rail_sample_period];
  assign phase_end = timer_reg == phase_len - 18'h1;
  // sign-extended counts keep their 2.5uV weight
  assign acc_sum = (seq_reg == SEQ_DROP && phase_end) ?
                   acc_reg + {{10{drop_sample[15]}}, drop_sample} : acc_reg;
  // arithmetic shift keeps the sign in bit 15
  assign avg_value = 16'(acc_sum >>> avg_shift);

  always_comb begin
    cfg_next = cfg_reg;
    drop_result_next = drop_result_reg;
    seq_next = seq_reg;
    timer_next = timer_reg;
    pass_next = pass_reg;
    acc_next = acc_reg;
    kick_next = kick_reg;
    strobe_next = 1'h0;
    done_next = 1'h0;
    end_pass = 1'h0;
    if (wr_cfg) begin
      if (wr.data[`SRST_BIT]) begin
        cfg_next = `CFG_RESET;
        drop_result_next = `DROP_RESET;
      end else begin
        cfg_next = {1'h0, `RSV_PATTERN, wr.data[`CFG_KEEP_HI:0]};
      end
      seq_next = SEQ_IDLE;
      timer_next = 18'h0;
      pass_next = 11'h0;
      acc_next = '0;
      kick_next = 1'h1;
    end else if (cfg_busy) begin
      // halt during write
      // a write cut off by stop must not leave continuous mode stalled
      kick_next = kick_reg | continuous;
      seq_next = SEQ_IDLE;
      timer_next = 18'h0;
      pass_next = 11'h0;
      acc_next = '0;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          if (kick_reg) begin
            kick_next = 1'h0;
            timer_next = 18'h0;
            if (!powerdown) begin
              seq_next = first_state;
            end
          end
        end
        SEQ_DROP: begin
          timer_next = timer_reg + 18'h1;
          if (phase_end) begin
            timer_next = 18'h0;
            acc_next = acc_sum;
            strobe_next = 1'h1;
            if (rail_en) begin
              seq_next = SEQ_RAIL;
            end else begin
              end_pass = 1'h1;
            end
          end
        end
        SEQ_RAIL: begin
          timer_next = timer_reg + 18'h1;
          if (phase_end) begin
            timer_next = 18'h0;
            end_pass = 1'h1;
          end
        end
        default: begin
          seq_next = SEQ_IDLE;
        end
      endcase
      if (end_pass) begin
        seq_next = first_state;
        pass_next = pass_reg + 11'h1;
        if (pass_reg == pass_last) begin
          pass_next = 11'h0;
          acc_next = '0;
          done_next = 1'h1;
          if (drop_en) begin
            drop_result_next = avg_value;
          end
          if (!continuous) begin
            seq_next = SEQ_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= `CFG_RESET;
      drop_result_reg <= `DROP_RESET;
      seq_reg <= SEQ_IDLE;
      timer_reg <= 18'h0;
      pass_reg <= 11'h0;
      acc_reg <= '0;
      kick_reg <= 1'h1;
      strobe_reg <= 1'h0;
      done_reg <= 1'h0;
    end else begin
      cfg_reg <= cfg_next;
      drop_result_reg <= drop_result_next;
      seq_reg <= seq_next;
      timer_reg <= timer_next;
      pass_reg <= pass_next;
      acc_reg <= acc_next;
      kick_reg <= kick_next;
      strobe_reg <= strobe_next;
      done_reg <= done_next;
    end
  end

  assign sample_taken = strobe_reg;
  assign conv_done = done_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fixed_bits_a: assert property (cfg_reg.fixed_bits == `RSV_PATTERN && !cfg_reg.srst)
    else $error("setup fixed bits or reset bit wrong");
  soft_reset_a: assert property (wr_cfg && wr.data[`SRST_BIT] |=>
      cfg_reg == `CFG_RESET && drop_result_reg == `DROP_RESET)
    else $error("soft reset did not restore defaults");
  auto_start_a: assert property (wr_cfg && wr.data[`SRST_BIT] |=> ##1 seq_reg == SEQ_DROP)
    else $error("no conversion after soft reset");
  write_halt_a: assert property (wr_cfg || cfg_busy |=>
      seq_reg == SEQ_IDLE && timer_reg == 18'h0 && pass_reg == 11'h0)
    else $error("conversion not halted by setup write");
  drop_time_a: assert property (strobe_reg |->
      $past(timer_reg) == ct_cycles[$past(cfg_reg.drop_sample_period)] - 18'h1)
    else $error("drop conversion length wrong");
  rail_time_a: assert property (seq_reg == SEQ_RAIL |->
      timer_reg < ct_cycles[cfg_reg.rail_sample_period])
    else $error("rail conversion overran");
  avg_count_a: assert property (done_reg |-> $past(pass_reg) == pass_last)
    else $error("average sample count wrong");
  result_hold_a: assert property (!done_reg && !$past(wr_cfg) |->
      $stable(drop_result_reg))
    else $error("result changed without finished average");
  avg_sign_a: assert property (!wr_cfg && !cfg_busy && end_pass && pass_reg == pass_last
      && drop_en |=> drop_result_reg == $past(avg_value))
    else $error("result not the signed average");
  single_code_a: assert property (done_reg && drop_en && !rail_en
      && cfg_reg.sample_count_select == 3'h0 && !$past(wr_cfg)
      |-> drop_result_reg == $past(drop_sample))
    else $error("single sample code not passed through");
  op_decode_a: assert property ((seq_reg == SEQ_DROP |-> drop_en)
      and (seq_reg == SEQ_RAIL |-> rail_en))
    else $error("phase runs for a disabled channel");
  trig_idle_a: assert property (done_reg && !continuous && !wr_cfg && !cfg_busy
      |=> seq_reg == SEQ_IDLE)
    else $error("triggered mode kept converting");
  pd_idle_a: assert property (seq_reg == SEQ_IDLE && powerdown |=> seq_reg == SEQ_IDLE)
    else $error("power-down started a conversion");

  cover property (wr_cfg && wr.data[`SRST_BIT]);
  cover property (done_reg && continuous);
  cover property (done_reg && !continuous);
  cover property (done_reg && drop_result_reg[15]);

endmodule : monitor_conversion_config

// [verif/wire_host.sv]
`include "monitor_consts.svh"

module wire_host (
  // clock and wire
  input wire logic clk,
  input wire logic sda_line,
  // driven pins
  output logic scl,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // data moves mid-low so no false start or stop is seen
  task automatic bitx(input logic b, output logic r);
    wt(2);
    sda_oe <= ~b;
    wt(2);
    scl <= 1'b1;
    wt(4);
    r = sda_line;
    scl <= 1'b0;
  endtask : bitx
  task automatic start();
    wt(2);
    sda_oe <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_oe <= 1'b1;
    wt(4);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    wt(2);
    sda_oe <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_oe <= 1'b0;
    wt(4);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask : rbyte
  // word as high then low byte
  task automatic wreg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                      output logic ok);
    logic [3:0] k;
    start();
    wbyte({a, 1'b0}, k[0]);
    wbyte(p, k[1]);
    wbyte(d[15:8], k[2]);
    wbyte(d[7:0], k[3]);
    stop();
    ok = &k;
  endtask : wreg
  task automatic rreg(input logic [7:0] p, output logic [15:0] d);
    logic k;
    start();
    wbyte({`DEV_ADDR, 1'b0}, k);
    wbyte(p, k);
    start();
    wbyte({`DEV_ADDR, 1'b1}, k);
    rbyte(1'b0, d[15:8]);
    rbyte(1'b1, d[7:0]);
    stop();
  endtask : rreg
endmodule : wire_host

// [verif/monitor_conversion_config_test.sv]
`include "monitor_consts.svh"

module monitor_conversion_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] ct [8] = '{18'h14, 18'h18, 18'h1C, 18'h20, 18'h24, 18'h28,
                                     18'h2C, 18'h30};
  localparam int navg [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
  localparam int trs [4] = '{0, 7, 0, 3};
  localparam int tds [4] = '{0, 0, 7, 5};
  localparam int pmode [4] = '{6, 2, 0, 4};
  localparam int pdone [4] = '{2, 1, 0, 0};
  logic clk, rst, scl, host_oe, sda_line, sda_out, sda_oe, sample_taken, conv_done, ramp;
  logic [15:0] drop_sample, s0;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0, taken = 0, done = 0, last_t = 0, gap = 0, nt = 0, nd = 0;
  // pull-up wire, any low driver wins
  assign sda_line = ~(host_oe | sda_oe);
  monitor_conversion_config #(.ct_cycles(ct)) u_monitor_conversion_config (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .drop_sample(drop_sample), .sample_taken(sample_taken),
    .conv_done(conv_done));
  wire_host u_wire_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_oe(host_oe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sample_taken) begin
      taken <= taken + 1;
      gap <= cyc - last_t;
      last_t <= cyc;
      if (ramp) drop_sample <= drop_sample + 16'h0004;
    end
    if (conv_done) done <= done + 1;
    // run needs about 58k cycles
    if (cyc == 90000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] cfg(input int a, input int r, input int d, input int m);
    return {4'h4, 3'(a), 3'(r), 3'(d), 3'(m)};
  endfunction : cfg
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic ok;
    u_wire_host.wreg(`DEV_ADDR, p, d, ok);
    check("ack", 16'(ok), 16'h0001);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] p, input logic [15:0] e);
    logic [15:0] v;
    u_wire_host.rreg(p, v);
    check(what, v, e);
  endtask : rd
  task automatic wait_taken(input int n);
    int t0;
    t0 = taken;
    for (int i = 0; i < 2000 && taken < t0 + n; i++) @(posedge clk);
  endtask : wait_taken
  // stop set: wait for a finished set; else count over a fixed span
  task automatic run_set(input logic [15:0] c, input int lim, input bit stop);
    int t0, d0;
    t0 = taken;
    d0 = done;
    wr(8'h00, c);
    if (!stop) begin
      t0 = taken;
      d0 = done;
    end
    for (int i = 0; i < lim && !(stop && done != d0); i++) @(posedge clk);
    repeat (4) @(posedge clk);
    nt = taken - t0;
    nd = done - d0;
  endtask : run_set
  initial begin
    rst = 1'b1;
    ramp = 1'b0;
    drop_sample = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd("setup", 8'h00, 16'h4127);
    rd("result", 8'h01, 16'h0000);
    rd("unmapped", 8'h05, 16'h0000);
    check("running", 16'(taken > 0), 16'h0001);
    check("pin drive", 16'(sda_out), 16'h0000);
    $display("reset test done");
    wr(8'h00, 16'h3E23);
    rd("setup", 8'h00, 16'h4E23);
    wr(8'h01, 16'h1234);
    rd("result", 8'h01, 16'h0000);
    $display("access test done");
    for (int j = 0; j < 4; j++) begin
      wr(8'h00, cfg(0, trs[j], tds[j], 7));
      wait_taken(3);
      // one pass is a drop phase plus a rail phase
      check("period", 16'(gap), 16'(ct[trs[j]] + ct[tds[j]]));
    end
    $display("timing test done");
    for (int j = 0; j < 4; j++) begin
      run_set(cfg(0, 7, 0, pmode[j]), 300, 1'b0);
      check("drop samples", 16'(nt), 16'h0000);
      check("sets", 16'(nd > 1 ? 2 : nd), 16'(pdone[j]));
      rd("setup", 8'h00, cfg(0, 7, 0, pmode[j]));
    end
    $display("mode test done");
    drop_sample <= 16'hE000;
    ramp <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      @(posedge clk);
      s0 = drop_sample;
      run_set(cfg(a, 0, 0, 1), 60000, 1'b1);
      check("samples", 16'(nt), 16'(navg[a]));
      rd("average", 8'h01, s0 + 16'(2 * (navg[a] - 1)));
    end
    nt = taken;
    repeat (200) @(posedge clk);
    check("idle", 16'(taken - nt), 16'h0000);
    $display("averaging test done");
    ramp <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      drop_sample <= j ? 16'h8300 : 16'h7FFF;
      run_set(cfg(2, 0, 0, 1), 1000, 1'b1);
      rd("scale", 8'h01, j ? 16'h8300 : 16'h7FFF);
    end
    $display("scale test done");
    wr(8'h00, 16'hFFFF);
    rd("setup", 8'h00, 16'h4127);
    wait_taken(3);
    check("default period", 16'(gap), 16'(2 * ct[4]));
    $display("soft reset test done");
    summarize();
  end
endmodule : monitor_conversion_config_test
